// *** hdl/asq2_step2_config.sv ***
/*
 * Sequence step 2 configuration register of the multiplexed auxiliary
 * converter, with the decode that the sequencer applies when it reaches step 2.
 * Assumes a simple register port on clk_sys from the device's register logic
 * and a sequencer on the same clock that pulses a step-2 request.
 */
`timescale 1ns/1ps
`include "asq2_cfg.svh"

// Functional notes
// - Bit 15 enables step 2, reset 0
// - Bits 14:13 gain 1, 2, 4, 4
// - Bits 12:5 reserved, read zero
// - Bit 4 negative: ground or input 7
// - Codes 0000-0111 pick external inputs 0-7
// - Codes 1000 upward pick internal sources
// - Internal sources ignore negative selector bit
// - Positive selector resets to 0010
// - Address 92h, whole reset value 0002h
module asq2_step2_config
    import asq2_pkg::*;
(
    // Clock and reset
    input  wire logic                     clk_sys,
    input  wire logic                     arst_n,
    // Register port
    input  wire logic [`ASQ2_ADDR_W-1:0]  reg_addr,
    input  wire logic                     reg_wr_en,
    input  wire logic [`ASQ2_DATA_W-1:0]  reg_wr_data,
    input  wire logic                     reg_rd_en,
    output logic      [`ASQ2_DATA_W-1:0]  reg_rd_data,
    output logic                          reg_rd_valid,
    // Sequencer handshake
    input  wire logic                     seq_step2_req,
    output logic                          seq_step2_run,
    output logic                          seq_step2_skip,
    // Live configuration and applied settings
    output asq2_fields_t                  step2_fields,
    output asq2_apply_t                   step2_apply
);

    ////////////////////////////////////////////////////////////////////////////
    // Reset release

    logic [1:0] rst_sync_ff;                // Two-stage release of arst_n
    logic       rst_n;                      // Synchronised reset for the block

    // Assert at once, release after two edges
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rst_sync_ff <= `ASQ2_SYNC_RST;
        end
        else
        begin
            rst_sync_ff <= {rst_sync_ff[0], `ASQ2_SYNC_ONE};
        end
    end

    assign rst_n = rst_sync_ff[1];

    ////////////////////////////////////////////////////////////////////////////
    // Register storage

    asq2_fields_t fields_ff;                // Stored writable fields
    asq2_fields_t nxt_fields;               // Next value of stored fields
    logic         addr_hit;                 // Access targets this register

    assign addr_hit = (reg_addr == `ASQ2_STEP2_ADDR);

    // Writes land only on a matching address; reserved bits are dropped
    always_comb
    begin
        nxt_fields = fields_ff;
        if (reg_wr_en && addr_hit)
        begin
            nxt_fields.step2_enable_bit            = reg_wr_data[`ASQ2_EN_BIT];
            nxt_fields.step2_gain_select           = reg_wr_data[`ASQ2_GAIN_HI:`ASQ2_GAIN_LO];
            nxt_fields.step2_negative_input_select = reg_wr_data[`ASQ2_NEG_BIT];
            nxt_fields.step2_positive_input_select = reg_wr_data[`ASQ2_POS_HI:`ASQ2_POS_LO];
        end
    end

    // Field reset values make up the whole-register reset image
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            fields_ff.step2_enable_bit            <= `ASQ2_EN_RST;
            fields_ff.step2_gain_select           <= `ASQ2_GAIN_RST;
            fields_ff.step2_negative_input_select <= `ASQ2_NEG_RST;
            fields_ff.step2_positive_input_select <= `ASQ2_POS_RST;
        end
        else
        begin
            fields_ff <= nxt_fields;
        end
    end

    assign step2_fields = fields_ff;

    ////////////////////////////////////////////////////////////////////////////
    // Read path

    logic [`ASQ2_DATA_W-1:0] rd_data_ff;    // Registered read data
    logic [`ASQ2_DATA_W-1:0] nxt_rd_data;   // Next read data
    logic                    rd_valid_ff;   // Read answer strobe
    logic                    nxt_rd_valid;  // Next read strobe

    // Unmapped reads return zero; reserved field always zero
    always_comb
    begin
        nxt_rd_data  = '0;
        nxt_rd_valid = reg_rd_en;
        if (reg_rd_en && addr_hit)
        begin
            nxt_rd_data[`ASQ2_EN_BIT]               = fields_ff.step2_enable_bit;
            nxt_rd_data[`ASQ2_GAIN_HI:`ASQ2_GAIN_LO] = fields_ff.step2_gain_select;
            nxt_rd_data[`ASQ2_RSVD_HI:`ASQ2_RSVD_LO] = '0;
            nxt_rd_data[`ASQ2_NEG_BIT]              = fields_ff.step2_negative_input_select;
            nxt_rd_data[`ASQ2_POS_HI:`ASQ2_POS_LO]   = fields_ff.step2_positive_input_select;
        end
    end

    // Read answer one cycle after the request
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rd_data_ff  <= '0;
            rd_valid_ff <= 1'h0;
        end
        else
        begin
            rd_data_ff  <= nxt_rd_data;
            rd_valid_ff <= nxt_rd_valid;
        end
    end

    assign reg_rd_data  = rd_data_ff;
    assign reg_rd_valid = rd_valid_ff;

    ////////////////////////////////////////////////////////////////////////////
    // Source decode

    logic [2:0]    gain_factor;             // Decoded gain factor
    logic          pos_internal;            // Positive code picks internal source
    asq2_neg_src_t neg_source;              // Effective negative input

    // Codes 10 and 11 both give gain 4
    always_comb
    begin
        unique case (fields_ff.step2_gain_select)
            `ASQ2_GAIN_CODE_X1: gain_factor = `ASQ2_GAIN_FACTOR_X1;
            `ASQ2_GAIN_CODE_X2: gain_factor = `ASQ2_GAIN_FACTOR_X2;
            default:            gain_factor = `ASQ2_GAIN_FACTOR_X4;
        endcase
    end

    // Every code from 1000 up is internal, ambiguous 1011 and 1101 included
    always_comb
    begin
        unique case (fields_ff.step2_positive_input_select)
            `ASQ2_POS_TEMP,
            `ASQ2_POS_SHORT,
            `ASQ2_POS_TDAC,
            `ASQ2_POS_TDAC_ALIAS,
            `ASQ2_POS_IO_Q,
            `ASQ2_POS_IO_H,
            `ASQ2_POS_ANA_SUP,
            `ASQ2_POS_DIG_SUP: pos_internal = 1'h1;
            default:        pos_internal = 1'h0;
        endcase
    end

    // Internal sources choose their own negative input
    always_comb
    begin
        if (pos_internal)
        begin
            neg_source = ASQ2_NEG_AUTOMATIC;
        end
        else if (fields_ff.step2_negative_input_select)
        begin
            neg_source = ASQ2_NEG_EXT_INPUT_7;
        end
        else
        begin
            neg_source = ASQ2_NEG_ANALOG_GROUND;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer hand-off

    asq2_apply_t apply_ff;                  // Settings held for the converter
    asq2_apply_t nxt_apply;                 // Next applied settings
    logic        run_ff;                    // Step runs this cycle
    logic        nxt_run;                   // Next run pulse
    logic        skip_ff;                   // Step skipped this cycle
    logic        nxt_skip;                  // Next skip pulse

    // Settings are latched at the run so a later write cannot disturb a
    // conversion already under way
    always_comb
    begin
        nxt_apply = apply_ff;
        nxt_run   = seq_step2_req && fields_ff.step2_enable_bit;
        nxt_skip  = seq_step2_req && !fields_ff.step2_enable_bit;
        if (nxt_run)
        begin
            nxt_apply.gain_factor       = gain_factor;
            nxt_apply.positive_code     = fields_ff.step2_positive_input_select;
            nxt_apply.positive_internal = pos_internal;
            nxt_apply.negative_source   = neg_source;
        end
    end

    // Applied settings start from the reset configuration
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            apply_ff.gain_factor       <= `ASQ2_GAIN_FACTOR_X1;
            apply_ff.positive_code     <= `ASQ2_POS_RST;
            apply_ff.positive_internal <= 1'h0;
            apply_ff.negative_source   <= ASQ2_NEG_ANALOG_GROUND;
            run_ff                     <= 1'h0;
            skip_ff                    <= 1'h0;
        end
        else
        begin
            apply_ff <= nxt_apply;
            run_ff   <= nxt_run;
            skip_ff  <= nxt_skip;
        end
    end

    assign step2_apply    = apply_ff;
    assign seq_step2_run  = run_ff;
    assign seq_step2_skip = skip_ff;

endmodule

// *** hdl/asq2_cfg.svh ***
/*
 * Constants for the auxiliary converter sequence step 2 configuration register:
 * address, field positions, reset values and source codes.
 * Assumes it is included by bare name from the package and the design module.
 */
`ifndef ASQ2_CFG_SVH
`define ASQ2_CFG_SVH

// Register address and width
`define ASQ2_ADDR_W          8
`define ASQ2_DATA_W          16
`define ASQ2_STEP2_ADDR      8'h92
`define ASQ2_STEP2_RESET     16'h0002

// Field positions
`define ASQ2_EN_BIT          15
`define ASQ2_GAIN_HI         14
`define ASQ2_GAIN_LO         13
`define ASQ2_RSVD_HI         12
`define ASQ2_RSVD_LO         5
`define ASQ2_NEG_BIT         4
`define ASQ2_POS_HI          3
`define ASQ2_POS_LO          0

// Field reset values
`define ASQ2_EN_RST          1'h0
`define ASQ2_GAIN_RST        2'h0
`define ASQ2_NEG_RST         1'h0
`define ASQ2_POS_RST         4'h2

// Gain codes and resulting factors
`define ASQ2_GAIN_CODE_X1    2'h0
`define ASQ2_GAIN_CODE_X2    2'h1
`define ASQ2_GAIN_FACTOR_X1  3'h1
`define ASQ2_GAIN_FACTOR_X2  3'h2
`define ASQ2_GAIN_FACTOR_X4  3'h4

// Positive-input codes for internal sources
`define ASQ2_POS_TEMP        4'h8
`define ASQ2_POS_SHORT       4'h9
`define ASQ2_POS_TDAC        4'ha
`define ASQ2_POS_TDAC_ALIAS  4'hb
`define ASQ2_POS_IO_Q        4'hc
`define ASQ2_POS_IO_H        4'hd
`define ASQ2_POS_ANA_SUP     4'he
`define ASQ2_POS_DIG_SUP     4'hf

// Reset synchroniser constants
`define ASQ2_SYNC_RST        2'h0
`define ASQ2_SYNC_ONE        1'h1

`endif

// *** hdl/asq2_pkg.sv ***
/*
 * Types shared by the step 2 configuration block: register image and
 * decoded source selections handed to the sequencer and converter front end.
 * Assumes asq2_cfg.svh is on the include path.
 */
`include "asq2_cfg.svh"

package asq2_pkg;

    // Stored fields of the step 2 register
    typedef struct packed {
        logic       step2_enable_bit;
        logic [1:0] step2_gain_select;
        logic       step2_negative_input_select;
        logic [3:0] step2_positive_input_select;
    } asq2_fields_t;

    // Negative input choice seen by the converter
    typedef enum logic [1:0] {
        ASQ2_NEG_ANALOG_GROUND = 2'h0,
        ASQ2_NEG_EXT_INPUT_7   = 2'h1,
        ASQ2_NEG_AUTOMATIC     = 2'h2
    } asq2_neg_src_t;

    // Settings applied to the converter when step 2 runs
    typedef struct packed {
        logic [2:0]    gain_factor;
        logic [3:0]    positive_code;
        logic          positive_internal;
        asq2_neg_src_t negative_source;
    } asq2_apply_t;

endpackage

// *** verification/asq2_step2_config_monitor.sv ***
/*
 * Checker for the step 2 register: read answers, writes, sequencer pulses.
 * Assumes it is bound to asq2_step2_config on one clock domain.
 */
`timescale 1ns/1ps
`include "asq2_cfg.svh"
module asq2_step2_config_monitor
    import asq2_pkg::*;
(
    // Clock and reset
    input wire logic                    clk_sys,
    input wire logic                    arst_n,
    // Register port
    input wire logic [`ASQ2_ADDR_W-1:0] reg_addr,
    input wire logic                    reg_wr_en,
    input wire logic [`ASQ2_DATA_W-1:0] reg_wr_data,
    input wire logic                    reg_rd_en,
    input wire logic [`ASQ2_DATA_W-1:0] reg_rd_data,
    input wire logic                    reg_rd_valid,
    // Sequencer and settings
    input wire logic                    seq_step2_req,
    input wire logic                    seq_step2_run,
    input wire logic                    seq_step2_skip,
    input wire asq2_fields_t            step2_fields,
    input wire asq2_apply_t             step2_apply
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!arst_n);
    // Address match, read image and settings expected at a run
    logic        hit;
    logic [15:0] img;
    asq2_apply_t ea;
    assign hit = reg_addr == `ASQ2_STEP2_ADDR;
    assign img = {step2_fields[7:5], 8'h00, step2_fields[4:0]};
    // Internal codes force the automatic negative input
    assign ea = {step2_fields[6:5] == 2'h0 ? 3'h1 : (step2_fields[6:5] == 2'h1 ? 3'h2 : 3'h4),
                 step2_fields[3:0], step2_fields[3],
                 step2_fields[3] ? 2'h2 : {1'b0, step2_fields[4]}};
    ////////////////////////////////////////////////////////////////
    property p_rd_valid;
        reg_rd_valid == $past(reg_rd_en);
    endproperty
    a_rd_valid: assert property (p_rd_valid) else $error("read strobe not answered");
    property p_rd_data;
        reg_rd_en && hit |=> reg_rd_data == $past(img);
    endproperty
    a_rd_data: assert property (p_rd_data) else $error("read image wrong");
    property p_rd_other;
        reg_rd_en && !hit |=> reg_rd_data == 16'h0000;
    endproperty
    a_rd_other: assert property (p_rd_other) else $error("unmapped read not zero");
    property p_rsvd;
        reg_rd_valid |-> reg_rd_data[12:5] == 8'h00;
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved bits not zero");
    property p_wr;
        reg_wr_en && hit |=> step2_fields == {$past(reg_wr_data[15:13]), $past(reg_wr_data[4:0])};
    endproperty
    a_wr: assert property (p_wr) else $error("write not stored");
    property p_hold;
        !(reg_wr_en && hit) |=> $stable(step2_fields);
    endproperty
    a_hold: assert property (p_hold) else $error("fields changed without write");
    property p_run;
        seq_step2_req |=> (seq_step2_run ^ seq_step2_skip) && seq_step2_run == $past(step2_fields[7]);
    endproperty
    a_run: assert property (p_run) else $error("run or skip wrong");
    property p_idle;
        !seq_step2_req |=> !seq_step2_run && !seq_step2_skip;
    endproperty
    a_idle: assert property (p_idle) else $error("pulse without request");
    property p_apply;
        seq_step2_run |-> step2_apply == $past(ea);
    endproperty
    a_apply: assert property (p_apply) else $error("applied settings wrong");
    property p_apply_hold;
        !seq_step2_run |-> $stable(step2_apply);
    endproperty
    a_apply_hold: assert property (p_apply_hold) else $error("settings moved without run");
endmodule
bind asq2_step2_config asq2_step2_config_monitor asq2_step2_config_monitor_i (.clk_sys(clk_sys),
    .arst_n(arst_n), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en), .reg_wr_data(reg_wr_data),
    .reg_rd_en(reg_rd_en), .reg_rd_data(reg_rd_data), .reg_rd_valid(reg_rd_valid),
    .seq_step2_req(seq_step2_req), .seq_step2_run(seq_step2_run), .seq_step2_skip(seq_step2_skip),
    .step2_fields(step2_fields), .step2_apply(step2_apply));

// *** verification/tb_asq2_step2_config.sv ***
/*
 * Self-checking bench for the step 2 register against an integer model.
 * Assumes the header, package and design compile first.
 */
`timescale 1ns/1ps
`include "asq2_cfg.svh"
module tb_asq2_step2_config
    import asq2_pkg::*;
;
    // Design inputs and outputs
    logic         clk_sys, arst_n, reg_wr_en, reg_rd_en, seq_step2_req;
    logic         reg_rd_valid, seq_step2_run, seq_step2_skip;
    logic [7:0]   reg_addr;
    logic [15:0]  reg_wr_data, reg_rd_data, d;
    asq2_fields_t step2_fields;
    asq2_apply_t  step2_apply;
    // Model fields, last applied settings, counters
    int           m_en, m_gain, m_neg, m_pos, fail_count, comparisons;
    logic [9:0]   m_apply;
    asq2_step2_config asq2_step2_config_i (.clk_sys(clk_sys), .arst_n(arst_n), .reg_addr(reg_addr),
        .reg_wr_en(reg_wr_en), .reg_wr_data(reg_wr_data), .reg_rd_en(reg_rd_en), .reg_rd_data(reg_rd_data),
        .reg_rd_valid(reg_rd_valid), .seq_step2_req(seq_step2_req), .seq_step2_run(seq_step2_run),
        .seq_step2_skip(seq_step2_skip), .step2_fields(step2_fields), .step2_apply(step2_apply));
    ////////////////////////////////////////////////////////////////
    // 100 ns clock
    initial
    begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end
    // One compare, counted
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        comparisons++;
        if (g !== e)
        begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask
    // Model image of the register; reserved bits always zero
    function automatic logic [15:0] img();
        return {m_en[0], m_gain[1:0], 8'h00, m_neg[0], m_pos[3:0]};
    endfunction
    // One-cycle write strobe; model follows only the mapped address
    task automatic wr(input logic [7:0] a, input logic [15:0] v);
        @(posedge clk_sys);
        reg_addr    <= a;
        reg_wr_data <= v;
        reg_wr_en   <= 1'b1;
        @(posedge clk_sys);
        reg_wr_en   <= 1'b0;
        if (a == `ASQ2_STEP2_ADDR)
        begin
            m_en   = v[15];
            m_gain = v[14:13];
            m_neg  = v[4];
            m_pos  = v[3:0];
        end
    endtask
    // Read answer stands one cycle, so it is looked at right after the edge
    task automatic rd(input logic [7:0] a, input logic [15:0] e);
        @(posedge clk_sys);
        reg_addr  <= a;
        reg_rd_en <= 1'b1;
        @(posedge clk_sys);
        reg_rd_en <= 1'b0;
        #1;
        chk("rd_valid", 16'h0001, {15'h0, reg_rd_valid});
        chk("rd_data", e, reg_rd_data);
        chk("fields", {8'h00, m_en[0], m_gain[1:0], m_neg[0], m_pos[3:0]}, {8'h00, step2_fields});
    endtask
    // Sequencer pulse; settings change only on a run
    task automatic step();
        @(posedge clk_sys);
        seq_step2_req <= 1'b1;
        @(posedge clk_sys);
        seq_step2_req <= 1'b0;
        #1;
        if (m_en != 0)
            m_apply = {m_gain == 0 ? 3'h1 : (m_gain == 1 ? 3'h2 : 3'h4), m_pos[3:0], m_pos >= 8,
                       m_pos >= 8 ? 2'h2 : 2'(m_neg)};
        chk("run", 16'(m_en), {15'h0, seq_step2_run});
        chk("skip", 16'(m_en == 0), {15'h0, seq_step2_skip});
        chk("apply", {6'h0, m_apply}, {6'h0, step2_apply});
    endtask
    // Reset the model to the register's reset image
    task automatic do_reset();
        arst_n <= 1'b0;
        repeat (8) @(posedge clk_sys);
        arst_n  <= 1'b1;
        {m_en, m_gain, m_neg, m_pos} = {32'd0, 32'd0, 32'd0, 32'd2};
        m_apply = {3'h1, 4'h2, 1'b0, 2'h0};
        repeat (3) @(posedge clk_sys);
    endtask
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////
    // Main sequence
    initial
    begin
        {reg_wr_en, reg_rd_en, seq_step2_req, reg_addr, reg_wr_data} = '0;
        void'($urandom(3));
        do_reset();
        rd(8'h92, 16'h0002);
        rd(8'h91, 16'h0000);
        step();
        $display("test reset done");
        // Every positive code, all gains, both enables; a foreign write between
        for (int i = 0; i < 32; i++)
        begin
            d = 16'($urandom);
            d[3:0] = 4'(i);
            d[14:13] = 2'(i >> 1);
            d[15] = i[4];
            d[4] = i[0] ^ i[4];
            wr(8'h92, d);
            wr(8'h92 ^ 8'(1 + $urandom % 255), ~d);
            rd(8'h92, img());
            step();
        end
        $display("test codes done");
        // Second reset after traffic restores the reset image
        do_reset();
        rd(8'h92, 16'h0002);
        step();
        $display("test rereset done");
        finish_test();
    end
    // Watchdog: the run needs some 290 cycles, 20000 is ample
    initial
    begin
        #2000000;
        fail_count++;
        finish_test();
    end
endmodule
